//--- fault_summary_status.sv
`timescale 1ns/100ps
// Behaviour
// - category summary bit is OR of that fault category over all four channels.
// - category summary register reads 0x80 after reset, supply bit set.
// - bit 7 set on logic supply lockout or main supply undervoltage.
// - bit 6 set on blocked reverse current in any channel.
// - bit 5 set on thermal shutdown in any channel.
// - bit 4 set on current-limit fault in any channel.
// - bit 3 set on on-state wire break in any channel.
// - bit 2 set on off-state wire break in any channel.
// - bit 1 set on off-state short to supply in any channel.
// - bit 0 set on serial, watchdog, low supply warning or chip thermal warning.
// - with latching on, bits hold until detail read and condition gone.
// - supply and global bits release on global detail read when faults are gone.
// - channel category bits release on read of their own detail register.
// - channel summary at offset 1 resets 0x00, bit per channel ORs the six channel fault categories, not supply or global.
// - channel summary bits 3..0 are channels four..one, bits 7..4 read zero.
// - with latching on, global undervoltage and warning state clears on read only after condition removed.
module fault_summary_status
  import fault_summary_pkg::*;
(
  input wire logic i_clock, // 10 MHz device clock
  input wire logic i_rst, // power-on reset, async, active high
  input wire logic i_fault_latch_control, // 1 = summary bits latch
  input wire logic [NUM_CATEGORIES*NUM_CHANNELS-1:0] i_channel_fault, // [cat*4+ch], async
  input wire logic i_logic_supply_lockout, // async
  input wire logic i_main_supply_undervoltage, // async
  input wire logic [NUM_GLOBAL_WARN-1:0] i_global_warn, // serial, watchdog, low, thermal
  input wire logic [NUM_DETAIL_READS-1:0] i_detail_read, // one-cycle detail read pulses
  input wire logic i_read_en, // one-cycle read strobe
  input wire logic [ADDR_WIDTH-1:0] i_read_addr, // register offset
  output logic [DATA_WIDTH-1:0] o_read_data, // read answer
  output logic o_read_valid, // answer valid pulse
  output logic [DATA_WIDTH-1:0] o_category_summary, // fault_category_summary
  output logic [DATA_WIDTH-1:0] o_channel_summary // faulted_channel_summary
);
  localparam int LIVE_WIDTH = NUM_CATEGORIES*NUM_CHANNELS + 2 + NUM_GLOBAL_WARN;

  logic [LIVE_WIDTH-1:0] sync1_reg, sync2_reg;
  logic [NUM_CATEGORIES*NUM_CHANNELS-1:0] ch_live;
  logic supply_live, global_live;
  logic [NUM_CATEGORIES*NUM_CHANNELS-1:0] lat_reg, lat_next;
  logic supply_reg, supply_next, global_reg, global_next;
  logic [NUM_CATEGORIES-1:0] cat_any;
  logic [NUM_CHANNELS-1:0] chan_any;
  logic [DATA_WIDTH-1:0] cat_sum_next, chan_sum_next, rd_data_next;

  // two-stage synchronisers for analog fault inputs
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {i_global_warn, i_main_supply_undervoltage, i_logic_supply_lockout,
                    i_channel_fault};
      sync2_reg <= sync1_reg;
    end
  end

  assign ch_live = sync2_reg[NUM_CATEGORIES*NUM_CHANNELS-1:0];
  assign supply_live = |sync2_reg[NUM_CATEGORIES*NUM_CHANNELS +: 2];
  assign global_live = |sync2_reg[NUM_CATEGORIES*NUM_CHANNELS+2 +: NUM_GLOBAL_WARN];

  // with latch on, clear only with read and condition gone, else follow live; a live fault keeps the bit set
  function automatic logic next_flag(input logic cur, input logic live, input logic latch,
                                     input logic rd);
    if (!latch)
      next_flag = live;
    else
      next_flag = live | (cur & ~rd);
  endfunction

  always_comb begin
    for (int i = 0; i < NUM_CATEGORIES*NUM_CHANNELS; i++) begin
      lat_next[i] = next_flag(lat_reg[i], ch_live[i], i_fault_latch_control,
                              i_detail_read[i/NUM_CHANNELS]);
    end
    supply_next = next_flag(supply_reg, supply_live, i_fault_latch_control,
                            i_detail_read[DETAIL_READ_GLOBAL]);
    global_next = next_flag(global_reg, global_live, i_fault_latch_control,
                            i_detail_read[DETAIL_READ_GLOBAL]);
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      lat_reg <= '0;
      supply_reg <= RESET_SUPPLY_LATCH;
      global_reg <= 1'b0;
    end else begin
      lat_reg <= lat_next;
      supply_reg <= supply_next;
      global_reg <= global_next;
    end
  end

  genvar gk, gc;
  generate
    for (gk = 0; gk < NUM_CATEGORIES; gk++) begin : g_cat
      assign cat_any[gk] = |lat_reg[gk*NUM_CHANNELS +: NUM_CHANNELS];
    end
    for (gc = 0; gc < NUM_CHANNELS; gc++) begin : g_chan
      logic [NUM_CATEGORIES-1:0] per_cat;
      for (gk = 0; gk < NUM_CATEGORIES; gk++) begin : g_bit
        assign per_cat[gk] = lat_reg[gk*NUM_CHANNELS + gc];
      end
      assign chan_any[gc] = |per_cat;
    end
  endgenerate

  always_comb begin
    cat_sum_next = '0;
    cat_sum_next[BIT_SUPPLY_FAULT] = supply_reg;
    for (int k = 0; k < NUM_CATEGORIES; k++) begin
      cat_sum_next[BIT_REVERSE_BLOCK-k] = cat_any[k];
    end
    cat_sum_next[BIT_GLOBAL_ERROR] = global_reg;
    chan_sum_next = {{(DATA_WIDTH-NUM_CHANNELS){1'b0}}, chan_any};
    case (i_read_addr)
      OFFSET_CATEGORY_SUMMARY: rd_data_next = o_category_summary;
      OFFSET_CHANNEL_SUMMARY: rd_data_next = o_channel_summary;
      default: rd_data_next = UNMAPPED_READ_VALUE;
    endcase
    if (!i_read_en)
      rd_data_next = o_read_data;
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_category_summary <= RESET_CATEGORY_SUMMARY;
      o_channel_summary <= RESET_CHANNEL_SUMMARY;
      o_read_data <= '0;
      o_read_valid <= 1'b0;
    end else begin
      o_category_summary <= cat_sum_next;
      o_channel_summary <= chan_sum_next;
      o_read_data <= rd_data_next;
      o_read_valid <= i_read_en;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  // register view: reset value, reserved bits, live reporting
  chk_reset_category_value: assert property ($fell(i_rst) |->
      o_category_summary == RESET_CATEGORY_SUMMARY)
    else $error("category summary not 0x80 after reset");
  chk_reserved_chan_bits: assert property (o_channel_summary[7:4] == 4'h0)
    else $error("channel summary reserved bits set");
  chk_supply_or_bit: assert property (supply_live |-> ##2 o_category_summary[7])
    else $error("supply fault not reported in bit 7");
  chk_global_or_bit: assert property (global_live |-> ##2 o_category_summary[0])
    else $error("global error not reported in bit 0");
  chk_chan_summary_or: assert property (##1 o_channel_summary[3:0] == $past(chan_any))
    else $error("channel summary does not follow channel faults");

  // supply and global latches
  chk_supply_release: assert property (i_fault_latch_control && supply_reg &&
      i_detail_read[DETAIL_READ_GLOBAL] && !supply_live |=> !supply_reg)
    else $error("supply latch not released by global read");
  chk_global_release: assert property (i_fault_latch_control && global_reg &&
      i_detail_read[DETAIL_READ_GLOBAL] && !global_live |=> !global_reg)
    else $error("global latch not released by global read");
  chk_supply_latch_hold: assert property (i_fault_latch_control && supply_reg &&
      !i_detail_read[DETAIL_READ_GLOBAL] |=> supply_reg)
    else $error("latched supply fault lost without global read");
  chk_global_latch_hold: assert property (i_fault_latch_control && global_reg &&
      !i_detail_read[DETAIL_READ_GLOBAL] |=> global_reg)
    else $error("latched global error lost without global read");
  chk_supply_set_wins: assert property (supply_live |=> supply_reg)
    else $error("live supply fault did not hold its latch");
  chk_global_set_wins: assert property (global_live |=> global_reg)
    else $error("live global error did not hold its latch");
  chk_live_follow_mode: assert property ((!i_fault_latch_control ##1 !i_fault_latch_control)
      |=> o_category_summary[0] == $past(global_live, 2))
    else $error("global bit does not follow live state");
  chk_supply_live_follow: assert property ((!i_fault_latch_control ##1 !i_fault_latch_control)
      |=> o_category_summary[BIT_SUPPLY_FAULT] == $past(supply_live, 2))
    else $error("supply bit does not follow live state");
  chk_summary_read_pure: assert property (i_read_en &&
      !i_detail_read[DETAIL_READ_GLOBAL] && i_fault_latch_control && global_reg |=> global_reg)
    else $error("summary read altered a latched bit");

  // read path: the answer is the register value before the strobe edge
  chk_read_category: assert property (i_read_en &&
      i_read_addr == OFFSET_CATEGORY_SUMMARY |=> o_read_data == $past(o_category_summary))
    else $error("category summary read returned a wrong value");
  chk_read_channel: assert property (i_read_en &&
      i_read_addr == OFFSET_CHANNEL_SUMMARY |=> o_read_data == $past(o_channel_summary))
    else $error("channel summary read returned a wrong value");
  chk_read_unmapped: assert property (i_read_en &&
      i_read_addr != OFFSET_CATEGORY_SUMMARY && i_read_addr != OFFSET_CHANNEL_SUMMARY
      |=> o_read_data == UNMAPPED_READ_VALUE)
    else $error("unmapped read did not return zero");
  chk_read_valid_pulse: assert property (o_read_valid == $past(i_read_en))
    else $error("read valid does not follow the read strobe");
  chk_read_data_hold: assert property (!i_read_en |=> $stable(o_read_data))
    else $error("read data changed without a read");

  // per-bit checks; category k sits on summary bit BIT_REVERSE_BLOCK - k
  generate
    for (gk = 0; gk < NUM_CATEGORIES*NUM_CHANNELS; gk++) begin : g_chk
      chk_cat_or_bit: assert property (ch_live[gk] |-> ##2
          o_category_summary[BIT_REVERSE_BLOCK - gk/NUM_CHANNELS])
        else $error("category bit misses a channel fault");
      chk_chan_or_bit: assert property (ch_live[gk] |-> ##2
          o_channel_summary[gk % NUM_CHANNELS])
        else $error("channel bit misses a channel fault");
      chk_latch_hold: assert property (i_fault_latch_control && lat_reg[gk] &&
          !i_detail_read[gk/NUM_CHANNELS] |=> lat_reg[gk])
        else $error("latched fault lost without detail read");
      chk_detail_release: assert property (i_fault_latch_control &&
          i_detail_read[gk/NUM_CHANNELS] && !ch_live[gk] |=> !lat_reg[gk])
        else $error("latched fault not released by detail read");
    end
  endgenerate

  // main scenarios
  cov_latched_release: cover property (i_fault_latch_control && supply_reg ##1 !supply_reg);
  cov_live_fault: cover property (!i_fault_latch_control && cat_any[0] ##2 o_category_summary[6]);
  cov_chan_fault: cover property (o_channel_summary[3]);
  cov_summary_read: cover property (i_read_en && i_read_addr == OFFSET_CHANNEL_SUMMARY);
  cov_global_held: cover property (i_fault_latch_control && global_reg && !global_live);
endmodule

//--- fault_summary_pkg.sv
package fault_summary_pkg;
  localparam int NUM_CHANNELS = 4;
  localparam int NUM_CATEGORIES = 6;
  localparam int NUM_GLOBAL_WARN = 4;
  localparam int ADDR_WIDTH = 6;
  localparam int DATA_WIDTH = 8;
  // register offsets
  localparam logic [5:0] OFFSET_CATEGORY_SUMMARY = 6'h00;
  localparam logic [5:0] OFFSET_CHANNEL_SUMMARY = 6'h01;
  // reset values and unmapped read value
  localparam logic [7:0] RESET_CATEGORY_SUMMARY = 8'h80;
  localparam logic [7:0] RESET_CHANNEL_SUMMARY = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;
  localparam logic RESET_SUPPLY_LATCH = 1'b1;
  // category summary bit positions
  localparam int BIT_SUPPLY_FAULT = 7;
  localparam int BIT_REVERSE_BLOCK = 6;
  localparam int BIT_GLOBAL_ERROR = 0;
  // category index k (0 reverse, 1 overtemp, 2 overcurrent, 3 on open,
  // 4 off open, 5 supply short) lands on summary bit BIT_REVERSE_BLOCK - k
  localparam int DETAIL_READ_GLOBAL = 6;
  localparam int NUM_DETAIL_READS = 7;
endpackage

//--- host_model.sv
`timescale 1ns/100ps
module host_model (
  input wire logic i_clock, // device clock
  input wire logic [7:0] i_read_data, // read answer
  input wire logic i_read_valid, // answer pulse
  output logic o_read_en = 1'b0, // read strobe
  output logic [5:0] o_read_addr = 6'h00 // register offset
);
  // one-cycle strobe; the answer is taken while its valid pulse stands
  task automatic read_reg(input logic [5:0] addr, output logic [7:0] data);
    o_read_en = 1'b1;
    o_read_addr = addr;
    @(posedge i_clock);
    #1;
    o_read_en = 1'b0;
    o_read_addr = ~addr;
    data = (i_read_valid === 1'b1) ? i_read_data : 8'hXX;
    @(posedge i_clock);
    #1;
  endtask
endmodule

//--- testbench.sv
`timescale 1ns/100ps
module testbench;
  import fault_summary_pkg::*;
  logic i_clock = 1'b0, i_rst = 1'b1, latch = 1'b0, rd_en, rd_valid;
  logic [23:0] chan_fault = 24'h000000;
  logic [5:0] misc = 6'h00, rd_addr;
  logic [6:0] det_rd = 7'h00;
  logic [7:0] rd_data, cat_sum, ch_sum, got, exp;
  int mismatches = 0, checks_done = 0;
  fault_summary_status dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_fault_latch_control(latch),
    .i_channel_fault(chan_fault), .i_logic_supply_lockout(misc[0]),
    .i_main_supply_undervoltage(misc[1]), .i_global_warn(misc[5:2]), .i_detail_read(det_rd),
    .i_read_en(rd_en), .i_read_addr(rd_addr), .o_read_data(rd_data),
    .o_read_valid(rd_valid), .o_category_summary(cat_sum), .o_channel_summary(ch_sum));
  host_model host_u (.i_clock(i_clock), .i_read_data(rd_data), .i_read_valid(rd_valid),
    .o_read_en(rd_en), .o_read_addr(rd_addr));
  initial begin
    forever #50 i_clock = ~i_clock;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic expect_reg(input logic [5:0] addr, input logic [7:0] e);
    host_u.read_reg(addr, got);
    cmp(got, e);
  endtask
  task automatic pulse(input int k);
    det_rd[k] = 1'b1;
    tick(1);
    det_rd = 7'h00;
    tick(1);
  endtask
  task automatic conclude();
    if (mismatches == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    tick(20);
    cmp(cat_sum, RESET_CATEGORY_SUMMARY);
    cmp(ch_sum, RESET_CHANNEL_SUMMARY);
    i_rst = 1'b0;
    expect_reg(OFFSET_CATEGORY_SUMMARY, RESET_CATEGORY_SUMMARY);
    expect_reg(OFFSET_CHANNEL_SUMMARY, RESET_CHANNEL_SUMMARY);
    cmp(cat_sum, 8'h00);
    tick(5);
    expect_reg(6'h2A, UNMAPPED_READ_VALUE);
    for (int k = 0; k < 6; k++) begin
      for (int c = 0; c < 4; c++) begin
        chan_fault[k*4+c] = 1'b1;
        tick(5);
        expect_reg(OFFSET_CATEGORY_SUMMARY, 8'h40 >> k);
        expect_reg(OFFSET_CHANNEL_SUMMARY, 8'h01 << c);
        chan_fault[k*4+c] = 1'b0;
        tick(5);
        expect_reg(OFFSET_CATEGORY_SUMMARY, 8'h00);
      end
    end
    for (int j = 0; j < 6; j++) begin
      misc[j] = 1'b1;
      tick(5);
      expect_reg(OFFSET_CATEGORY_SUMMARY, (j < 2) ? 8'h80 : 8'h01);
      misc[j] = 1'b0;
      tick(5);
    end
    latch = 1'b1;
    pulse(DETAIL_READ_GLOBAL);
    for (int k = 0; k < 7; k++) begin
      exp = (k == 6) ? 8'h81 : 8'h40 >> k;
      if (k == 6)
        misc = 6'h3F;
      else
        chan_fault[k*4+3] = 1'b1;
      tick(5);
      pulse(k);
      chan_fault = 24'h000000;
      misc = 6'h00;
      tick(5);
      expect_reg(OFFSET_CATEGORY_SUMMARY, exp);
      expect_reg(OFFSET_CHANNEL_SUMMARY, (k == 6) ? 8'h00 : 8'h08);
      pulse((k + 1) % 7);
      tick(3);
      expect_reg(OFFSET_CATEGORY_SUMMARY, exp);
      pulse(k);
      tick(3);
      expect_reg(OFFSET_CATEGORY_SUMMARY, 8'h00);
      cmp(ch_sum, 8'h00);
    end
    conclude();
  end
  initial begin
    #500000;
    mismatches++;
    conclude();
  end
endmodule
